// [verilog/debug_guard_pkg.sv]
// shared constants and carrier types of the debug entry guard
package debug_guard_pkg;

	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int CMD_W = 4;
	localparam int CNT_W = 2;

	// register byte offsets
	localparam logic [ADDR_W-1:0] OFS_FREEZE_CTRL = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_MASK = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_STATE = 8'h0C;

	// test-port commands, shifted in msb first while mode select is high
	localparam logic [CMD_W-1:0] CMD_ENTER_DEBUG = 4'hA;
	localparam logic [CMD_W-1:0] CMD_EXIT_DEBUG = 4'h5;
	localparam logic [CNT_W-1:0] CNT_LAST = 2'h3;

	localparam logic [1:0] MOTOR_RUN_CONTINUE = 2'h0;
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic HRESP_OKAY = 1'h0;

	// freeze/run control word, top bit first, watchdog_frz at bit 0
	typedef struct packed {
		logic modulator_run_sel;
		logic [1:0] motor_run_sel;
		logic dma_honour;
		logic periodic_timer_frz;
		logic timed_bus_frz;
		logic can_frz;
		logic serial_frz;
		logic system_timer_frz;
		logic watchdog_frz;
	} freeze_ctrl_type;

	localparam int FREEZE_W = $bits(freeze_ctrl_type);
	localparam freeze_ctrl_type FREEZE_RESET = '0;

	// sticky events, top bit first, debug_entry at bit 0
	typedef struct packed {
		logic lockout;
		logic illegal_cmd;
		logic debug_entry;
	} status_type;

	localparam int STATUS_W = $bits(status_type);

	typedef struct packed {
		logic watchdog;
		logic system_timer;
		logic serial;
		logic can;
		logic timed_bus;
		logic periodic_timer;
		logic motor_timer;
		logic modulator;
		logic interrupt_ctrl;
		logic external_bus;
	} unit_run_type;

	typedef enum logic [1:0] {CTRL_HELD, CTRL_ACTIVE, CTRL_LOCKED} ctrl_state_type;

	typedef struct packed {
		logic pin_s1;
		logic pin_s2;
		logic tck_s1;
		logic tck_s2;
		logic tck_prev;
		logic tms_s1;
		logic tms_s2;
		logic tdi_s1;
		logic tdi_s2;
		ctrl_state_type ctrl;
		logic [CMD_W-1:0] shift;
		logic [CNT_W-1:0] count;
		logic debug_mode;
		logic lockout;
		logic fault_pulse;
		freeze_ctrl_type freeze;
		status_type status;
		status_type mask;
		logic addr_valid;
		logic addr_write;
		logic [ADDR_W-1:0] addr;
		logic ready;
		logic [DATA_W-1:0] rdata;
		logic irq;
		unit_run_type run;
		logic dma_debug_req;
	} guard_state_type;

endpackage

// [verilog/debug_entry_guard.sv]
// debug entry guard: test-port gate, debug fault report, per-unit freeze
//
// Behaviour
// R1 - enable pin low holds test-port controller in reset, no debug
// R2 - test access enable pin high releases the controller so debug can enter
// R3 - board keeps the test access enable pin low in normal operation
// R4 - every entry into debug mode reports a fault to the fault collector
// R5 - after collector flags erroneous entry, test-port commands are ignored
// R6 - watchdog freeze bit 0: watchdog keeps counting in debug
// R7 - system timer freeze bit 0: system timer keeps running in debug
// R8 - serial unit freeze bit 0: serial transfers complete in debug
// R9 - can freeze bit 0: can controller keeps communicating in debug
// R10 - timed bus freeze bit 0: timed bus keeps communicating in debug
// R11 - periodic timer freeze bit 0: periodic timer keeps running in debug
// R12 - dma honour bit 0: dma ignores debug request, keeps transferring
// R13 - motor timer run select 00: motor timer runs on in debug
// R14 - modulator run select 1: modulator keeps running in debug
// R15 - interrupt controller behaves in debug exactly as in normal mode
// R16 - external bus unit is unaffected by debug mode
// R17 - freeze bit 1: unit halts in debug and resumes when debug ends
//
// Implementation choices: the address map and the AHB-Lite register port.
`timescale 1ns/1ps

module debug_entry_guard (
	input wire logic mclk_i,
	input wire logic reset_n_i,
	input wire logic hsel_i,
	input wire logic [31:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic [2:0] hsize_i,
	input wire logic [31:0] hwdata_i,
	input wire logic hready_i,
	output logic hreadyout_o,
	output logic [31:0] hrdata_o,
	output logic hresp_o,
	input wire logic test_access_enable_pin_i,
	input wire logic test_clock_i,
	input wire logic test_mode_select_i,
	input wire logic test_data_i,
	input wire logic fault_erroneous_i,
	output logic test_ctrl_release_o,
	output logic debug_mode_o,
	output logic fault_report_o,
	output logic irq_o,
	output logic watchdog_run_o,
	output logic system_timer_run_o,
	output logic serial_unit_run_o,
	output logic can_unit_run_o,
	output logic timed_bus_run_o,
	output logic periodic_timer_run_o,
	output logic dma_debug_request_o,
	output logic motor_timer_run_o,
	output logic modulator_run_o,
	output logic interrupt_ctrl_run_o,
	output logic external_bus_run_o
);

	debug_guard_pkg::guard_state_type state;
	debug_guard_pkg::guard_state_type next;

	function automatic logic reg_hit(
		input logic [debug_guard_pkg::ADDR_W-1:0] a,
		input logic [debug_guard_pkg::ADDR_W-1:0] ofs
	);
		reg_hit = (a == ofs);
	endfunction

	always_comb
	begin
		logic rise;
		logic done;
		logic wr;
		logic entry_evt;
		logic illegal_evt;
		logic lock_evt;
		logic dbg;
		logic [debug_guard_pkg::CMD_W-1:0] cmd;
		debug_guard_pkg::status_type w1c;
		debug_guard_pkg::freeze_ctrl_type f;
		rise = 1'b0;
		done = 1'b0;
		wr = 1'b0;
		entry_evt = 1'b0;
		illegal_evt = 1'b0;
		lock_evt = 1'b0;
		dbg = 1'b0;
		cmd = '0;
		w1c = '0;
		f = '0;
		next = state;

		// pins from the debugger's domain, two stages before use
		next.pin_s1 = test_access_enable_pin_i;
		next.pin_s2 = state.pin_s1;
		next.tck_s1 = test_clock_i;
		next.tck_s2 = state.tck_s1;
		next.tck_prev = state.tck_s2;
		next.tms_s1 = test_mode_select_i;
		next.tms_s2 = state.tms_s1;
		next.tdi_s1 = test_data_i;
		next.tdi_s2 = state.tdi_s1;
		rise = state.tck_s2 & ~state.tck_prev;

		// command shifter, shared by active and locked controller
		cmd = {state.shift[debug_guard_pkg::CMD_W-2:0], state.tdi_s2};
		if (state.ctrl != debug_guard_pkg::CTRL_HELD && rise)
		begin
			if (state.tms_s2)
			begin
				next.shift = cmd;
				next.count = state.count + 1'b1;
				done = (state.count == debug_guard_pkg::CNT_LAST);
			end
			else
			begin
				next.count = '0;
			end
		end

		unique case (state.ctrl)
			debug_guard_pkg::CTRL_HELD:
			begin
				if (state.pin_s2)
				begin
					next.ctrl = state.lockout ? debug_guard_pkg::CTRL_LOCKED
						: debug_guard_pkg::CTRL_ACTIVE; // [R2]
				end
			end
			debug_guard_pkg::CTRL_ACTIVE:
			begin
				if (done && cmd == debug_guard_pkg::CMD_ENTER_DEBUG)
				begin
					next.debug_mode = 1'b1;
					entry_evt = ~state.debug_mode; // [R4]
				end
				else if (done && cmd == debug_guard_pkg::CMD_EXIT_DEBUG)
				begin
					next.debug_mode = 1'b0; // [R17]
				end
				else if (done)
				begin
					illegal_evt = 1'b1;
				end
			end
			debug_guard_pkg::CTRL_LOCKED:
			begin
				// every finished command counts as illegal and does nothing
				illegal_evt = done; // [R5]
			end
		endcase

		// erroneous entry seen by the collector locks the port until reset
		if (fault_erroneous_i && !state.lockout)
		begin
			next.lockout = 1'b1;
			lock_evt = 1'b1;
		end
		// looks at the state just chosen, so a release this cycle is caught
		if (next.lockout && next.ctrl == debug_guard_pkg::CTRL_ACTIVE)
		begin
			next.ctrl = debug_guard_pkg::CTRL_LOCKED; // [R5]
		end

		// pin low wins over everything on the test port
		if (!state.pin_s2)
		begin
			next.ctrl = debug_guard_pkg::CTRL_HELD; // [R1]
			next.debug_mode = 1'b0; // [R1]
			next.count = '0;
			next.shift = '0;
			entry_evt = 1'b0;
			illegal_evt = 1'b0;
		end
		next.fault_pulse = entry_evt; // [R4]

		// bus data phase: write takes effect at its end
		wr = state.addr_valid & state.addr_write;
		if (wr && reg_hit(state.addr, debug_guard_pkg::OFS_FREEZE_CTRL))
		begin
			next.freeze = hwdata_i[debug_guard_pkg::FREEZE_W-1:0];
		end
		if (wr && reg_hit(state.addr, debug_guard_pkg::OFS_MASK))
		begin
			next.mask = hwdata_i[debug_guard_pkg::STATUS_W-1:0];
		end
		if (wr && reg_hit(state.addr, debug_guard_pkg::OFS_STATUS))
		begin
			w1c = hwdata_i[debug_guard_pkg::STATUS_W-1:0];
		end
		// set wins over a same-cycle clear
		next.status = (state.status & ~w1c)
			| {lock_evt, illegal_evt, entry_evt};
		next.irq = |(next.status & next.mask);

		// address phase
		next.ready = 1'b1;
		next.addr_valid = hsel_i & hready_i
			& (htrans_i == debug_guard_pkg::HTRANS_NONSEQ);
		next.addr_write = hwrite_i;
		next.addr = haddr_i[debug_guard_pkg::ADDR_W-1:0];
		// read data from next values so a write just before is seen
		next.rdata = '0;
		if (next.addr_valid && !hwrite_i)
		begin
			if (reg_hit(next.addr, debug_guard_pkg::OFS_FREEZE_CTRL))
			begin
				next.rdata[debug_guard_pkg::FREEZE_W-1:0] = next.freeze;
			end
			else if (reg_hit(next.addr, debug_guard_pkg::OFS_STATUS))
			begin
				next.rdata[debug_guard_pkg::STATUS_W-1:0] = next.status;
			end
			else if (reg_hit(next.addr, debug_guard_pkg::OFS_MASK))
			begin
				next.rdata[debug_guard_pkg::STATUS_W-1:0] = next.mask;
			end
			else if (reg_hit(next.addr, debug_guard_pkg::OFS_STATE))
			begin
				next.rdata[debug_guard_pkg::STATUS_W-1:0] = {next.lockout,
					next.ctrl != debug_guard_pkg::CTRL_HELD, next.debug_mode};
			end
		end

		// unit run enables follow the debug state and freeze word
		dbg = next.debug_mode;
		f = next.freeze;
		next.run.watchdog = ~(dbg & f.watchdog_frz); // [R6] [R17]
		next.run.system_timer = ~(dbg & f.system_timer_frz); // [R7] [R17]
		next.run.serial = ~(dbg & f.serial_frz); // [R8] [R17]
		next.run.can = ~(dbg & f.can_frz); // [R9] [R17]
		next.run.timed_bus = ~(dbg & f.timed_bus_frz); // [R10] [R17]
		next.run.periodic_timer = ~(dbg & f.periodic_timer_frz); // [R11]
		next.dma_debug_req = dbg & f.dma_honour; // [R12]
		next.run.motor_timer = ~dbg
			| (f.motor_run_sel == debug_guard_pkg::MOTOR_RUN_CONTINUE); // [R13]
		next.run.modulator = ~dbg | f.modulator_run_sel; // [R14]
		// no debug hook on these two units at all
		next.run.interrupt_ctrl = 1'b1; // [R15]
		next.run.external_bus = 1'b1; // [R16]
	end

	always_ff @(posedge mclk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			state <= '0;
			state.ctrl <= debug_guard_pkg::CTRL_HELD;
			state.freeze <= debug_guard_pkg::FREEZE_RESET;
			state.ready <= 1'b1;
			state.run <= '1;
		end
		else
		begin
			state <= next;
		end
	end

	assign hreadyout_o = state.ready;
	assign hrdata_o = state.rdata;
	assign hresp_o = debug_guard_pkg::HRESP_OKAY;
	assign test_ctrl_release_o = (state.ctrl != debug_guard_pkg::CTRL_HELD);
	assign debug_mode_o = state.debug_mode;
	assign fault_report_o = state.fault_pulse;
	assign irq_o = state.irq;
	assign watchdog_run_o = state.run.watchdog;
	assign system_timer_run_o = state.run.system_timer;
	assign serial_unit_run_o = state.run.serial;
	assign can_unit_run_o = state.run.can;
	assign timed_bus_run_o = state.run.timed_bus;
	assign periodic_timer_run_o = state.run.periodic_timer;
	assign dma_debug_request_o = state.dma_debug_req;
	assign motor_timer_run_o = state.run.motor_timer;
	assign modulator_run_o = state.run.modulator;
	assign interrupt_ctrl_run_o = state.run.interrupt_ctrl;
	assign external_bus_run_o = state.run.external_bus;

	default clocking cb @(posedge mclk_i);
	endclocking
	default disable iff (!reset_n_i);

	held_no_debug_a: assert property ( // [R1]
		!state.pin_s2 |=> !debug_mode_o && !test_ctrl_release_o)
		else $error("debug or release while enable pin low");
	release_ctrl_a: assert property ( // [R2]
		state.pin_s2 && !test_ctrl_release_o |=> test_ctrl_release_o)
		else $error("controller not released with pin high");
	entry_fault_a: assert property ( // [R4]
		$rose(debug_mode_o) |-> fault_report_o ##1 !fault_report_o)
		else $error("debug entry without one fault pulse");
	locked_ignore_a: assert property ( // [R5]
		state.lockout |=> !$rose(debug_mode_o) && !fault_report_o)
		else $error("command accepted after lockout");
	watchdog_run_a: assert property ( // [R6]
		debug_mode_o && !$past(state.freeze.watchdog_frz)
		&& !state.freeze.watchdog_frz |-> watchdog_run_o)
		else $error("watchdog stopped with freeze bit clear");
	timers_run_a: assert property ( // [R7]
		!state.freeze.system_timer_frz && !state.freeze.periodic_timer_frz
		|-> system_timer_run_o && periodic_timer_run_o)
		else $error("timer stopped with freeze bit clear");
	comms_run_a: assert property ( // [R8]
		!state.freeze.serial_frz && !state.freeze.can_frz
		&& !state.freeze.timed_bus_frz
		|-> serial_unit_run_o && can_unit_run_o && timed_bus_run_o)
		else $error("comm unit stopped with freeze bit clear");
	dma_ignore_a: assert property ( // [R12]
		!state.freeze.dma_honour |-> !dma_debug_request_o)
		else $error("dma debug request with honour clear");
	motor_pwm_a: assert property ( // [R13]
		debug_mode_o |-> (motor_timer_run_o == (state.freeze.motor_run_sel
		== debug_guard_pkg::MOTOR_RUN_CONTINUE))
		&& (modulator_run_o == state.freeze.modulator_run_sel))
		else $error("motor or modulator run wrong in debug");
	always_on_a: assert property ( // [R15]
		interrupt_ctrl_run_o && external_bus_run_o)
		else $error("interrupt or bus unit affected by debug");
	freeze_resume_a: assert property ( // [R17]
		debug_mode_o && state.freeze.watchdog_frz && !watchdog_run_o
		##1 !debug_mode_o |-> watchdog_run_o)
		else $error("frozen unit did not resume after debug");
	// one check per unit for can, timed bus, periodic timer, dma, modulator and external bus, so a broken gate names its own unit
	can_run_a: assert property ( // [R9]
		!state.freeze.can_frz |-> can_unit_run_o)
		else $error("can unit stopped with freeze bit clear");
	timed_bus_run_a: assert property ( // [R10]
		!state.freeze.timed_bus_frz |-> timed_bus_run_o)
		else $error("timed bus stopped with freeze bit clear");
	periodic_run_a: assert property ( // [R11]
		!state.freeze.periodic_timer_frz |-> periodic_timer_run_o)
		else $error("periodic timer stopped with freeze bit clear");
	dma_honour_a: assert property ( // [R12]
		debug_mode_o && state.freeze.dma_honour |-> dma_debug_request_o)
		else $error("dma debug request missing with honour set");
	modulator_run_a: assert property ( // [R14]
		state.freeze.modulator_run_sel |-> modulator_run_o)
		else $error("modulator stopped with run select set");
	bus_unit_run_a: assert property ( // [R16]
		external_bus_run_o)
		else $error("external bus unit affected by debug");
	entry_only_fault_a: assert property ( // [R4]
		fault_report_o |-> $rose(debug_mode_o) && state.status.debug_entry)
		else $error("fault pulse without debug entry");
	held_clear_a: assert property ( // [R1]
		!test_ctrl_release_o |-> state.count == '0 && state.shift == '0)
		else $error("command shifter busy while controller held");
	locked_state_a: assert property ( // [R5]
		state.lockout && test_ctrl_release_o
		|-> state.ctrl == debug_guard_pkg::CTRL_LOCKED)
		else $error("test port active after lockout");
	freeze_halt_a: assert property ( // [R17]
		debug_mode_o && state.freeze.can_frz |-> !can_unit_run_o)
		else $error("frozen unit runs in debug");
	timer_halt_a: assert property ( // [R17]
		debug_mode_o && state.freeze.system_timer_frz
		&& state.freeze.periodic_timer_frz
		|-> !system_timer_run_o && !periodic_timer_run_o)
		else $error("frozen timer runs in debug");
	serial_halt_a: assert property ( // [R17]
		debug_mode_o && state.freeze.serial_frz |-> !serial_unit_run_o)
		else $error("frozen serial unit runs in debug");
	normal_run_a: assert property ( // [R17]
		!debug_mode_o |-> watchdog_run_o && system_timer_run_o
		&& serial_unit_run_o && can_unit_run_o && timed_bus_run_o
		&& periodic_timer_run_o && motor_timer_run_o && modulator_run_o
		&& !dma_debug_request_o)
		else $error("unit held outside debug");

	entry_c: cover property ($rose(debug_mode_o));
	lockout_c: cover property ($rose(state.lockout) ##[1:50] state.status[1]);
	freeze_c: cover property (debug_mode_o && !can_unit_run_o);
	irq_c: cover property ($rose(irq_o));
	exit_c: cover property ($fell(debug_mode_o) ##1 watchdog_run_o);

endmodule

// [test/debugger_model.sv]
// external debugger model driving the test port pins
`timescale 1ns/1ps

module debugger_model (
	input wire logic mclk_i,
	output logic pin_o,
	output logic tck_o,
	output logic tms_o,
	output logic tdi_o
);
	initial
	begin
		pin_o = 1'b0;
		tck_o = 1'b0;
		tms_o = 1'b0;
		tdi_o = 1'b0;
	end

	// board holds the pin low except while a debug session is wanted
	task automatic set_pin(input logic level);
		@(posedge mclk_i);
		#3 pin_o = level;
	endtask

	// clock stands still between commands, 200 ns a bit, msb first
	task automatic send_cmd(input logic [3:0] cmd);
		@(posedge mclk_i);
		#7 tms_o = 1'b1;
		for (int i = 3; i >= 0; i--)
		begin
			tdi_o = cmd[i];
			#100 tck_o = 1'b1;
			#100 tck_o = 1'b0;
		end
		tms_o = 1'b0;
		// released data line must not keep the last bit
		tdi_o = ~tdi_o;
	endtask
endmodule

// [test/testbench.sv]
// self-checking bench of the debug entry guard
`timescale 1ns/1ps

module testbench;
	logic mclk_i, reset_n_i, hsel_i, hwrite_i, hready_i, hresp_o;
	logic [31:0] haddr_i, hwdata_i, hrdata_o;
	logic [1:0] htrans_i;
	logic [2:0] hsize_i;
	logic hreadyout_o, test_access_enable_pin_i, test_clock_i;
	logic test_mode_select_i, test_data_i, fault_erroneous_i;
	logic test_ctrl_release_o, debug_mode_o, fault_report_o, irq_o;
	logic watchdog_run_o, system_timer_run_o, serial_unit_run_o;
	logic can_unit_run_o, timed_bus_run_o, periodic_timer_run_o;
	logic dma_debug_request_o, motor_timer_run_o, modulator_run_o;
	logic interrupt_ctrl_run_o, external_bus_run_o;
	int bad_count, comparisons, pulses;
	logic [31:0] rd;
	logic [9:0] f;

	debug_entry_guard dut (.mclk_i, .reset_n_i, .hsel_i, .haddr_i,
		.htrans_i, .hwrite_i, .hsize_i, .hwdata_i, .hready_i, .hreadyout_o,
		.hrdata_o, .hresp_o, .test_access_enable_pin_i, .test_clock_i,
		.test_mode_select_i, .test_data_i, .fault_erroneous_i,
		.test_ctrl_release_o, .debug_mode_o, .fault_report_o, .irq_o,
		.watchdog_run_o, .system_timer_run_o, .serial_unit_run_o,
		.can_unit_run_o, .timed_bus_run_o, .periodic_timer_run_o,
		.dma_debug_request_o, .motor_timer_run_o, .modulator_run_o,
		.interrupt_ctrl_run_o, .external_bus_run_o);

	debugger_model debugger (.mclk_i, .pin_o(test_access_enable_pin_i),
		.tck_o(test_clock_i), .tms_o(test_mode_select_i),
		.tdi_o(test_data_i));

	// single slave: its ready is the bus ready
	assign hready_i = hreadyout_o;

	initial
	begin
		mclk_i = 1'b0;
		forever #12.5 mclk_i = ~mclk_i;
	end

	// fault pulses counted in cycles high
	always @(posedge mclk_i)
		if (fault_report_o === 1'b1)
			pulses <= pulses + 1;

	task automatic test_done;
		$display("checks %0d mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic check(input logic [31:0] got, exp, input string what);
		comparisons++;
		if (got !== exp)
		begin
			bad_count++;
			$display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	// one single word transfer; zero wait states, but never assumed
	task automatic bus(input logic [7:0] a, input logic w,
		input logic [31:0] wd, output logic [31:0] r);
		int n;
		@(posedge mclk_i);
		hsel_i <= 1'b1;
		htrans_i <= debug_guard_pkg::HTRANS_NONSEQ;
		haddr_i <= {24'h000000, a};
		hwrite_i <= w;
		n = 0;
		do begin @(posedge mclk_i); n++; end while (hreadyout_o !== 1'b1 && n < 50);
		htrans_i <= 2'h0;
		hwdata_i <= wd;
		do begin @(posedge mclk_i); n++; end while (hreadyout_o !== 1'b1 && n < 100);
		r = hrdata_o;
		hsel_i <= 1'b0;
		if (n >= 100)
		begin
			bad_count++;
			test_done();
		end
	endtask

	task automatic rcheck(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] r;
		bus(a, 1'b0, 32'h00000000, r);
		check(r, exp, "register read");
	endtask

	function automatic logic [10:0] exp_run(input logic [9:0] f,
		input logic d);
		return {!(d & f[0]), !(d & f[1]), !(d & f[2]), !(d & f[3]),
			!(d & f[4]), !(d & f[5]), !d | (f[8:7] == 2'h0), !d | f[9],
			2'h3, d & f[6]};
	endfunction

	task automatic run_check(input logic [9:0] f, input logic d);
		@(posedge mclk_i);
		@(negedge mclk_i);
		check({watchdog_run_o, system_timer_run_o, serial_unit_run_o,
			can_unit_run_o, timed_bus_run_o, periodic_timer_run_o,
			motor_timer_run_o, modulator_run_o, interrupt_ctrl_run_o,
			external_bus_run_o, dma_debug_request_o}, exp_run(f, d), "run");
	endtask

	task automatic cmd(input logic [3:0] c);
		debugger.send_cmd(c);
		repeat (12) @(posedge mclk_i);
		@(negedge mclk_i);
	endtask

	initial
	begin
		#2000000;
		bad_count++;
		test_done();
	end

	initial
	begin
		{hsel_i, hwrite_i, fault_erroneous_i, htrans_i, pulses} = '0;
		{haddr_i, hwdata_i} = '0;
		hsize_i = 3'h2;
		reset_n_i = 1'b0;
		bad_count = 0;
		comparisons = 0;
		void'($urandom(32'hBDFC));
		repeat (5) @(posedge mclk_i);
		reset_n_i <= 1'b1;
		run_check(10'h000, 1'b0);
		check({debug_mode_o, test_ctrl_release_o, irq_o, hresp_o}, 0, "idle");
		rcheck(debug_guard_pkg::OFS_FREEZE_CTRL, 0);
		rcheck(debug_guard_pkg::OFS_MASK, 0);
		rcheck(8'h10, 0);
		cmd(debug_guard_pkg::CMD_ENTER_DEBUG);
		check({debug_mode_o, test_ctrl_release_o}, 0, "held");
		check(pulses, 0, "no fault while held");
		debugger.set_pin(1'b1);
		repeat (6) @(negedge mclk_i);
		check(test_ctrl_release_o, 1, "release");
		bus(debug_guard_pkg::OFS_MASK, 1'b1, 32'h00000001, rd);
		cmd(debug_guard_pkg::CMD_ENTER_DEBUG);
		check({debug_mode_o, irq_o}, 3, "entry");
		check(pulses, 1, "fault pulse");
		rcheck(debug_guard_pkg::OFS_STATUS, 1);
		for (int i = 0; i < 14; i++)
		begin
			f = (i < 2) ? {10{i[0]}} : 10'($urandom);
			bus(debug_guard_pkg::OFS_FREEZE_CTRL, 1'b1, {22'h0, f}, rd);
			run_check(f, 1'b1);
			rcheck(debug_guard_pkg::OFS_FREEZE_CTRL, {22'h0, f});
		end
		bus(debug_guard_pkg::OFS_FREEZE_CTRL, 1'b1, 32'h000003FF, rd);
		bus(debug_guard_pkg::OFS_STATUS, 1'b1, 32'h00000001, rd);
		@(negedge mclk_i);
		check(irq_o, 0, "irq cleared");
		rcheck(debug_guard_pkg::OFS_STATUS, 0);
		cmd(debug_guard_pkg::CMD_EXIT_DEBUG);
		check(debug_mode_o, 0, "exit");
		run_check(10'h3FF, 1'b0);
		debugger.set_pin(1'b0);
		repeat (6) @(negedge mclk_i);
		check(test_ctrl_release_o, 0, "held again");
		debugger.set_pin(1'b1);
		@(posedge mclk_i);
		fault_erroneous_i <= 1'b1;
		@(posedge mclk_i);
		fault_erroneous_i <= 1'b0;
		cmd(debug_guard_pkg::CMD_ENTER_DEBUG);
		check(debug_mode_o, 0, "locked out");
		check(pulses, 1, "no fault when locked");
		rcheck(debug_guard_pkg::OFS_STATUS, 32'h00000006);
		rcheck(debug_guard_pkg::OFS_STATE, 32'h00000006);
		test_done();
	end
endmodule
